// File: vic_core_model.sv
// Partner: core sequencer running a fixed-length service routine
`timescale 1ns/100ps
module vic_core_model #(
    parameter int unsigned ISR_LEN = 16
)(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  take_i,
    input  wire logic  stall_i,
    output logic       boundary_o,
    output logic       ret_o,
    output logic [15:0] pc_o
);
    logic [7:0] cnt_q;
    // Stall stands for a multi-cycle instruction
    assign boundary_o = !stall_i;
    assign ret_o = (cnt_q == 8'(ISR_LEN));
    always_ff @(posedge clk_i) begin
        pc_o <= rst_i ? 16'h0 : pc_o + 16'h1;
        if (rst_i || ret_o) begin
            cnt_q <= 8'h0;
        end else if (take_i || cnt_q != 8'h0) begin
            cnt_q <= cnt_q + 8'h1;
        end
    end
endmodule

// File: vic_ctrl.sv
// Interrupt control: gating, flags, priority, vector and core handshake
//
// Operation
// R1 - While the global disable is set no interrupt is taken; when clear any enabled source may be.
// R2 - Each source has an enable bit in the status and enable register that blocks it when clear.
// R3 - A peripheral request needs both the group enable and its own enable set.
// R4 - Reset sets the global disable so nothing is taken until software clears it.
// R5 - Accepting an interrupt sets the global disable, pushes the return address and loads the vector.
// R6 - The return-from-interrupt instruction pops the return address and clears the global disable.
// R7 - Pin vectors to 0008h, timer overflow to 0010h, timer clock pin to 0018h.
// R8 - Simultaneous enabled requests are served pin, timer, timer clock pin, then peripherals.
// R9 - All peripherals share the vector 0020h and software polls their flags.
// R10 - A flag is set by its event whatever its enable or the global disable.
// R11 - Software clears peripheral flags before re-enabling or the request repeats.
// R12 - Software should set the global disable before clearing any enable bit.
// R13 - An interrupt coinciding with an instruction setting the global disable is still taken.
// R14 - Software guarantees a global disable by setting it and reading it back until set.
// R15 - An interrupt is accepted only at an instruction boundary, evaluated in the selection cycle.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module vic_ctrl
    import vic_pkg::*;
#(
    parameter int unsigned NPERIPH = 4
)(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [VIC_ADR_W-1:0]  adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [VIC_DATA_W-1:0] dat_i,
    output logic [VIC_DATA_W-1:0]      dat_o,
    output logic                       ack_o,
    // Event pulses
    input  wire logic                  ext_irq_pin_i,
    input  wire logic                  timer_zero_ovf_i,
    input  wire logic                  timer_clk_input_pin_i,
    // Peripheral flags and enables held in the peripherals
    input  wire logic [NPERIPH-1:0]    periph_flag_i,
    input  wire logic [NPERIPH-1:0]    periph_en_i,
    // Core sequencer
    input  wire logic                  instr_boundary_i,
    input  wire logic                  return_from_irq_instr_i,
    input  wire logic                  core_gdis_set_i,
    input  wire logic [VIC_VEC_W-1:0]  return_addr_i,
    output logic                       irq_take_o,
    output logic [VIC_VEC_W-1:0]       vector_o,
    output logic                       push_o,
    output logic [VIC_VEC_W-1:0]       push_addr_o,
    output logic                       pop_o,
    output logic                       global_irq_disable_o
);
    logic                 gdis_q, gdis_d;
    logic [VIC_NSRC-1:0]  en_q, en_d;
    logic [2:0]           flag_q, flag_d;
    logic                 take_q, push_q, pop_q;
    logic [VIC_VEC_W-1:0] vec_q, paddr_q, last_vec_q;
    logic [VIC_DATA_W-1:0] dat_q;
    vic_state_type        state_q;

    logic                 wb_take, wr, rd;
    logic                 wr_cpu, wr_ise, wr_set;
    logic                 periph_flag, periph_req;
    logic [VIC_NSRC-1:0]  req;
    logic                 any_req, accept;
    logic [1:0]           sel_idx;
    logic [7:0]           ise_view;
    logic [VIC_DATA_W-1:0] rd_mux;
    logic [2:0]           flag_evt, flag_clr, flag_swset;

    vic_wb_slave u_wb (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cyc_i  (cyc_i),
        .stb_i  (stb_i),
        .ack_o  (ack_o),
        .take_o (wb_take)
    );

    assign wr     = wb_take & we_i & sel_i[0];
    assign rd     = wb_take & ~we_i;
    assign wr_cpu = wr & (adr_i == VIC_OFS_CPU_STATUS);
    assign wr_ise = wr & (adr_i == VIC_OFS_IRQ_STAT_EN);
    assign wr_set = wr & (adr_i == VIC_OFS_FLAG_SET);

    assign periph_flag = |(periph_flag_i & periph_en_i);
    assign periph_req  = periph_flag & en_q[VIC_BIT_PGRP_EN]; // R3

    // Gated requests in priority order
    assign req[VIC_SRC_PIN] = flag_q[VIC_SRC_PIN] & en_q[VIC_BIT_PIN_EN];
    assign req[VIC_SRC_TMR] = flag_q[VIC_SRC_TMR] & en_q[VIC_BIT_TMR_EN];
    assign req[VIC_SRC_TCK] = flag_q[VIC_SRC_TCK] & en_q[VIC_BIT_TCK_EN];
    assign req[VIC_SRC_PER] = periph_req; // R2

    vic_prio u_prio (
        .req_i (req),
        .any_o (any_req),
        .idx_o (sel_idx)
    );

    // Decision uses registered disable, so a same-cycle set does not block
    assign accept = any_req & ~gdis_q & instr_boundary_i
                  & (state_q == VIC_IDLE); // R1 R13 R15

    assign flag_evt = {timer_clk_input_pin_i, timer_zero_ovf_i,
                       ext_irq_pin_i}; // R10
    assign flag_clr = wr_ise ? ~dat_i[VIC_BIT_FLAG_LO +: 3] : 3'h0;
    assign flag_swset = wr_set ? dat_i[2:0] : 3'h0;
    // Event wins over a software clear in the same cycle
    assign flag_d = (flag_q & ~flag_clr) | flag_evt | flag_swset;

    assign en_d = wr_ise ? dat_i[VIC_BIT_PIN_EN +: VIC_NSRC] : en_q; // R2

    always_comb begin
        gdis_d = gdis_q;
        if (wr_cpu) begin
            gdis_d = dat_i[VIC_BIT_GDIS];
        end
        if (return_from_irq_instr_i) begin
            gdis_d = 1'b0; // R6
        end
        if (core_gdis_set_i) begin
            gdis_d = 1'b1;
        end
        if (accept) begin
            gdis_d = 1'b1; // R5
        end
    end

    assign ise_view = {periph_flag, flag_q, en_q};
    assign rd_mux =
        (adr_i == VIC_OFS_CPU_STATUS)  ?
            VIC_DATA_W'({gdis_q, {VIC_BIT_GDIS{1'b0}}}) : // R14
        (adr_i == VIC_OFS_IRQ_STAT_EN) ? VIC_DATA_W'(ise_view) : // R9
        (adr_i == VIC_OFS_VECTOR)      ? VIC_DATA_W'(last_vec_q) :
                                         '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gdis_q <= VIC_GDIS_RST; // R4
            en_q   <= VIC_EN_RST;
            flag_q <= 3'h0;
            dat_q  <= '0;
        end else begin
            gdis_q <= gdis_d;
            en_q   <= en_d;
            flag_q <= flag_d;
            if (rd) begin
                dat_q <= rd_mux;
            end
        end
    end

    // Core handshake: one-cycle take, push and vector together
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= VIC_IDLE;
            take_q     <= 1'b0;
            push_q     <= 1'b0;
            pop_q      <= 1'b0;
            vec_q      <= '0;
            paddr_q    <= '0;
            last_vec_q <= '0;
        end else begin
            take_q <= accept;
            push_q <= accept; // R5
            pop_q  <= return_from_irq_instr_i; // R6
            if (accept) begin
                vec_q      <= vic_vector(sel_idx); // R7 R9
                last_vec_q <= vic_vector(sel_idx);
                paddr_q    <= return_addr_i;
            end
            case (state_q)
                VIC_IDLE: begin
                    if (accept) begin
                        state_q <= VIC_ENTER;
                    end
                end
                VIC_ENTER: begin
                    // An early return must not strand the sequencer here
                    state_q <= return_from_irq_instr_i ? VIC_IDLE
                                                       : VIC_IN_ISR; // R6
                end
                VIC_IN_ISR: begin
                    if (return_from_irq_instr_i) begin
                        state_q <= VIC_IDLE;
                    end
                end
                default: begin
                    state_q <= VIC_IDLE;
                end
            endcase
        end
    end

    assign irq_take_o           = take_q;
    assign push_o               = push_q;
    assign pop_o                = pop_q;
    assign vector_o             = vec_q;
    assign push_addr_o          = paddr_q;
    assign dat_o                = dat_q;
    assign global_irq_disable_o = gdis_q;
endmodule

// File: vic_ctrl_chk.sv
// Checker: concurrent assertions on the interrupt control ports
`timescale 1ns/100ps
module vic_ctrl_chk
    import vic_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 cyc_i,
    input wire logic                 stb_i,
    input wire logic                 ack_o,
    input wire logic                 core_gdis_set_i,
    input wire logic                 instr_boundary_i,
    input wire logic                 return_from_irq_instr_i,
    input wire logic [VIC_VEC_W-1:0] return_addr_i,
    input wire logic                 irq_take_o,
    input wire logic                 push_o,
    input wire logic [VIC_VEC_W-1:0] push_addr_o,
    input wire logic                 pop_o,
    input wire logic [VIC_VEC_W-1:0] vector_o,
    input wire logic                 global_irq_disable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    AST_PUSH: assert property (irq_take_o == push_o)
        else $error("push not paired with accept");
    AST_GDIS: assert property (irq_take_o |-> global_irq_disable_o)
        else $error("disable not set on accept");
    AST_BLOCK: assert property (irq_take_o |-> !$past(global_irq_disable_o))
        else $error("accept while disabled");
    AST_BOUND: assert property (irq_take_o |-> $past(instr_boundary_i))
        else $error("accept off a boundary");
    AST_VEC: assert property (irq_take_o |-> vector_o inside
        {16'h0008, 16'h0010, 16'h0018, 16'h0020})
        else $error("bad vector");
    AST_RET: assert property (return_from_irq_instr_i &&
        !core_gdis_set_i |=> pop_o && (!global_irq_disable_o || irq_take_o))
        else $error("return did not pop and enable");
    AST_RST: assert property ($fell(rst_i) |->
        global_irq_disable_o && !irq_take_o && !pop_o)
        else $error("reset did not leave interrupts disabled");
    AST_ADDR: assert property (irq_take_o |->
        push_addr_o == $past(return_addr_i))
        else $error("wrong return address pushed");
endmodule

bind vic_ctrl vic_ctrl_chk u_chk (.*);

// File: vic_ctrl_tb.sv
// Testbench: bus-driven checks of the interrupt control
`timescale 1ns/100ps
module vic_ctrl_tb;
    import vic_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, stall_i = 1'b0;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic        ack_o, irq_take_o, push_o, pop_o, global_irq_disable_o;
    logic        ext_irq_pin_i = 1'b0, timer_zero_ovf_i = 1'b0;
    logic        timer_clk_input_pin_i = 1'b0, core_gdis_set_i = 1'b0;
    logic [3:0]  periph_flag_i = 4'h0, periph_en_i = 4'h0;
    logic        instr_boundary_i, return_from_irq_instr_i;
    logic [15:0] return_addr_i, vector_o, push_addr_o;
    logic [15:0] exp_vec [4] = '{VIC_VEC_PIN, VIC_VEC_TMR,
                                VIC_VEC_TCK, VIC_VEC_PER};
    logic [31:0] clr [4] = '{32'h6f, 32'h4f, 32'h0f, 32'h0f};
    int          errors = 0, n_compared = 0, n_take = 0;

    vic_ctrl u_dut (.*);
    vic_core_model u_core (.clk_i, .rst_i, .take_i(irq_take_o), .stall_i,
        .boundary_o(instr_boundary_i), .ret_o(return_from_irq_instr_i),
        .pc_o(return_addr_i));

    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (irq_take_o === 1'b1) n_take <= n_take + 1;

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Holds the request until ack is sampled, then releases it
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] s = 4'hf);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= s;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // Waits for a take pulse when take is set, else for a pop pulse
    task automatic wait_hi(input bit take);
        do @(posedge clk_i); while ((take ? irq_take_o : pop_o) !== 1'b1);
    endtask
    task final_report;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 4'h0, 0); chk(rd & 32'h10, 32'h10);
        wb(0, 4'h4, 0); chk(rd, 32'h0);
        wb(0, 4'h2, 0); chk(rd, 32'h0);
        ext_irq_pin_i <= 1'b1; timer_zero_ovf_i <= 1'b1;
        timer_clk_input_pin_i <= 1'b1;
        @(posedge clk_i);
        ext_irq_pin_i <= 1'b0; timer_zero_ovf_i <= 1'b0;
        timer_clk_input_pin_i <= 1'b0;
        wb(0, 4'h4, 0); chk(rd, 32'h70);
        periph_flag_i <= 4'h1;
        wb(1, 4'h4, 32'h78); wb(1, 4'h0, 0);
        repeat (8) @(posedge clk_i);
        chk(32'(n_take), 0);
        wb(1, 4'h0, 32'h10);
        periph_en_i <= 4'h1;
        wb(1, 4'h4, 32'h7f); wb(0, 4'h4, 0); chk(rd, 32'hff);
        chk(32'(n_take), 0);
        wb(1, 4'h0, 0);
        for (int i = 0; i < 4; i++) begin
            wait_hi(1'b1);
            chk(32'(vector_o), 32'(exp_vec[i]));
            chk(32'(global_irq_disable_o), 1);
            if (i == 3) periph_flag_i <= 4'h0;
            wb(1, 4'h4, clr[i]);
        end
        wait_hi(1'b0);
        // Stalled core must not be interrupted mid-instruction
        stall_i <= 1'b1;
        wb(1, 4'h8, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(32'(n_take), 4);
        stall_i <= 1'b0; core_gdis_set_i <= 1'b1;
        @(posedge clk_i);
        core_gdis_set_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(32'(n_take), 5);
        wb(1, 4'h4, 32'h0f); wait_hi(1'b0);
        wb(0, 4'h0, 0); chk(rd & 32'h10, 32'h0);
        wb(0, VIC_OFS_VECTOR, 0);
        chk(rd, 32'(VIC_VEC_PIN));
        // Byte lane 0 off: the disable write must be ignored
        wb(1, 4'h0, 32'h10, 4'he);
        wb(0, 4'h0, 0);
        chk(rd & 32'h10, 32'h0);
        do begin
            wb(1, 4'h0, 32'h10);
            wb(0, 4'h0, 0);
        end while (rd[VIC_BIT_GDIS] !== 1'b1);
        chk(rd & 32'h10, 32'h10);
        wb(1, 4'h4, 0);
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        final_report();
    end
endmodule

// File: vic_pkg.sv
// Package: register map, field positions and vectors of the interrupt control
package vic_pkg;
    localparam int unsigned VIC_DATA_W = 32;
    localparam int unsigned VIC_ADR_W  = 4;
    localparam int unsigned VIC_VEC_W  = 16;
    localparam int unsigned VIC_NSRC   = 4;

    // Register byte offsets (word aligned)
    localparam logic [VIC_ADR_W-1:0] VIC_OFS_CPU_STATUS = 4'h0;
    localparam logic [VIC_ADR_W-1:0] VIC_OFS_IRQ_STAT_EN = 4'h4;
    localparam logic [VIC_ADR_W-1:0] VIC_OFS_FLAG_SET   = 4'h8;
    localparam logic [VIC_ADR_W-1:0] VIC_OFS_VECTOR     = 4'hc;

    // cpu_status_reg fields
    localparam int unsigned VIC_BIT_GDIS = 4;

    // irq_status_enable_reg fields: enables in [3:0], flags in [7:4]
    localparam int unsigned VIC_BIT_PIN_EN  = 0;
    localparam int unsigned VIC_BIT_TMR_EN  = 1;
    localparam int unsigned VIC_BIT_TCK_EN  = 2;
    localparam int unsigned VIC_BIT_PGRP_EN = 3;
    localparam int unsigned VIC_BIT_FLAG_LO = 4;

    // Source index = priority order, 0 highest
    localparam int unsigned VIC_SRC_PIN = 0;
    localparam int unsigned VIC_SRC_TMR = 1;
    localparam int unsigned VIC_SRC_TCK = 2;
    localparam int unsigned VIC_SRC_PER = 3;

    localparam logic [VIC_VEC_W-1:0] VIC_VEC_PIN = 16'h0008;
    localparam logic [VIC_VEC_W-1:0] VIC_VEC_TMR = 16'h0010;
    localparam logic [VIC_VEC_W-1:0] VIC_VEC_TCK = 16'h0018;
    localparam logic [VIC_VEC_W-1:0] VIC_VEC_PER = 16'h0020;

    localparam logic VIC_GDIS_RST = 1'b1;
    localparam logic [VIC_NSRC-1:0] VIC_EN_RST = 4'h0;

    typedef enum logic [1:0] {
        VIC_IDLE,
        VIC_ENTER,
        VIC_IN_ISR
    } vic_state_type;

    function automatic logic [VIC_VEC_W-1:0] vic_vector(
        input logic [1:0] idx
    );
        case (idx)
            2'd0:    vic_vector = VIC_VEC_PIN;
            2'd1:    vic_vector = VIC_VEC_TMR;
            2'd2:    vic_vector = VIC_VEC_TCK;
            default: vic_vector = VIC_VEC_PER;
        endcase
    endfunction
endpackage

// File: vic_prio.sv
// Fixed priority selector over the gated requests
`timescale 1ns/100ps
module vic_prio
    import vic_pkg::*;
(
    input  wire logic [VIC_NSRC-1:0] req_i,
    output logic                     any_o,
    output logic [1:0]               idx_o
);
    assign any_o = |req_i;
    assign idx_o = req_i[VIC_SRC_PIN] ? 2'd0 :
                   req_i[VIC_SRC_TMR] ? 2'd1 :
                   req_i[VIC_SRC_TCK] ? 2'd2 : 2'd3; // R8
endmodule

// File: vic_wb_slave.sv
// Classic Wishbone slave handshake: one wait state, ack for one cycle
`timescale 1ns/100ps
module vic_wb_slave (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cyc_i,
    input  wire logic stb_i,
    output logic      ack_o,
    output logic      take_o
);
    logic ack_q;
    // Ack one cycle after request; dropped the cycle after so no double take
    assign take_o = cyc_i & stb_i & ~ack_q;
    assign ack_o  = ack_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= take_o;
        end
    end
endmodule
